//--- verilog/grseq_top.sv
// Grid overlay sequencer: start, pacing and end of the dot grid.
// Assumes sweep_gate_n is asynchronous; bus is zero-wait AHB-Lite.
//
// The register offsets and the AHB-Lite register port were decided locally.
`timescale 1ns/1ps
module grseq_top (
  input  wire logic        hclk,
  input  wire logic        hresetn,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic      [31:0] hrdata,
  output logic             hreadyout,
  output logic             hresp,
  input  wire logic        sweep_gate_n,
  output logic             sweep_lockout,
  output logic             beam_inhibit,
  output logic             deflection_source_select,
  output logic             column_ramp_reset,
  output logic             trimmed_sweep_gate,
  output logic             dot_pulse,
  output logic             vertical_clock
);
  localparam int CW = grseq_pkg::CW;

  function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
    hit = (a == off);
  endfunction

  function automatic logic [CW-1:0] dec(input logic [CW-1:0] v);
    dec = (v == '0) ? v : v - CW'(1);
  endfunction

  // Bus state
  logic                     wr_pend_ff,  nxt_wr_pend;
  logic [7:0]               wr_addr_ff,  nxt_wr_addr;
  logic [31:0]              hrdata_ff,   nxt_hrdata;
  logic                     hready_ff,   nxt_hready;
  logic                     hresp_ff,    nxt_hresp;
  grseq_pkg::grseq_ctrl_type ctrl_ff,    nxt_ctrl;
  logic [CW-1:0]            qual_len_ff, nxt_qual_len;
  logic [CW-1:0]            delay_ff,    nxt_delay;
  logic [CW-1:0]            dotw_ff,     nxt_dotw;

  // Sweep side state
  logic                     sync1_ff,    sync2_ff;
  logic                     sw_prev_ff,  nxt_sw_prev;
  logic                     qual_run_ff, nxt_qual_run;
  logic [CW-1:0]            qual_cnt_ff, nxt_qual_cnt;
  logic                     slow_ff,     nxt_slow;
  logic                     endp_ff,     nxt_endp;
  logic                     endp_d_ff,   nxt_endp_d;
  logic                     start_ff,    nxt_start;

  // Grid timing state
  grseq_pkg::grseq_state_type st_ff,     nxt_st;
  logic [5:0]               fast_cnt_ff, nxt_fast_cnt;
  logic [5:0]               line_cnt_ff, nxt_line_cnt;
  logic [2:0]               slow_cnt_ff, nxt_slow_cnt;
  logic [2:0]               div5_ff,     nxt_div5;
  logic                     major_ff,    nxt_major;
  logic [CW-1:0]            mos_cnt_ff,  nxt_mos_cnt;
  logic                     dot_en_ff,   nxt_dot_en;
  logic [CW-1:0]            dot_cnt_ff,  nxt_dot_cnt;
  logic [3:0]               col_cnt_ff,  nxt_col_cnt;
  logic                     gend_ff,     nxt_gend;
  grseq_pkg::grseq_out_type out_ff,      nxt_out;

  logic        addr_ok;
  logic        sw_act;
  logic        sw_rise;
  logic        sw_fall;
  logic        start_set;
  logic        vgate;
  logic        tick_fast;
  logic        tick_slow;
  logic        vclk;
  logic        major_now;
  logic        trig;
  logic [31:0] rd_mux;

  assign addr_ok = hsel & htrans[1] & hready;

  // Bus and register file
  always_comb
  begin
    nxt_wr_pend  = addr_ok & hwrite;
    nxt_wr_addr  = addr_ok ? haddr[7:0] : wr_addr_ff;
    nxt_hready   = 1'b1;
    nxt_hresp    = 1'b0;
    nxt_ctrl     = ctrl_ff;
    nxt_qual_len = qual_len_ff;
    nxt_delay    = delay_ff;
    nxt_dotw     = dotw_ff;
    if (wr_pend_ff)
    begin
      if (hit(wr_addr_ff, grseq_pkg::ADDR_CTRL))
        nxt_ctrl = hwdata[2:0];
      if (hit(wr_addr_ff, grseq_pkg::ADDR_QUAL))
        nxt_qual_len = hwdata[CW-1:0];
      if (hit(wr_addr_ff, grseq_pkg::ADDR_DELAY))
        nxt_delay = hwdata[CW-1:0];
      if (hit(wr_addr_ff, grseq_pkg::ADDR_DOTW))
        nxt_dotw = hwdata[CW-1:0];
    end
    // Read from next values so a write just before a read is seen
    rd_mux = 32'h0;
    if (hit(haddr[7:0], grseq_pkg::ADDR_CTRL))
      rd_mux = {29'h0, nxt_ctrl};
    if (hit(haddr[7:0], grseq_pkg::ADDR_QUAL))
      rd_mux = {16'h0, nxt_qual_len};
    if (hit(haddr[7:0], grseq_pkg::ADDR_DELAY))
      rd_mux = {16'h0, nxt_delay};
    if (hit(haddr[7:0], grseq_pkg::ADDR_DOTW))
      rd_mux = {16'h0, nxt_dotw};
    if (hit(haddr[7:0], grseq_pkg::ADDR_STATUS))
      rd_mux = {20'h0, col_cnt_ff, slow_ff, major_ff, st_ff, out_ff.ramp_rst,
                out_ff.lockout, out_ff.inhibit, start_ff};
    nxt_hrdata = (addr_ok & ~hwrite) ? rd_mux : hrdata_ff;
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      wr_pend_ff  <= 1'b0;
      wr_addr_ff  <= 8'h00;
      hrdata_ff   <= 32'h0;
      hready_ff   <= 1'b1;
      hresp_ff    <= 1'b0;
      ctrl_ff     <= grseq_pkg::CTRL_RST;
      qual_len_ff <= grseq_pkg::QUAL_RST;
      delay_ff    <= grseq_pkg::DELAY_RST;
      dotw_ff     <= grseq_pkg::DOTW_RST;
    end
    else
    begin
      wr_pend_ff  <= nxt_wr_pend;
      wr_addr_ff  <= nxt_wr_addr;
      hrdata_ff   <= nxt_hrdata;
      hready_ff   <= nxt_hready;
      hresp_ff    <= nxt_hresp;
      ctrl_ff     <= nxt_ctrl;
      qual_len_ff <= nxt_qual_len;
      delay_ff    <= nxt_delay;
      dotw_ff     <= nxt_dotw;
    end
  end

  // Pin synchroniser; only the second stage feeds logic
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      sync1_ff <= 1'b1;
      sync2_ff <= 1'b1;
    end
    else
    begin
      sync1_ff <= sweep_gate_n;
      sync2_ff <= sync1_ff;
    end
  end

  assign sw_act  = ~sync2_ff;
  assign sw_rise = sw_act & ~sw_prev_ff;
  assign sw_fall = ~sw_act & sw_prev_ff;
  // Narrow edge of the self-clearing end pulse
  assign start_set = endp_ff & ~endp_d_ff;

  // Sweep qualify and start flip-flop
  always_comb
  begin
    nxt_sw_prev  = sw_act;
    nxt_qual_run = qual_run_ff;
    nxt_qual_cnt = dec(qual_cnt_ff);
    nxt_slow     = slow_ff;
    if (qual_run_ff && qual_cnt_ff == CW'(1))
      nxt_qual_run = 1'b0;
    if (sw_rise)
    begin
      nxt_qual_run = 1'b1;
      nxt_qual_cnt = qual_len_ff;
    end
    if (sw_fall)
    begin
      nxt_slow     = ~qual_run_ff;
      nxt_qual_run = 1'b0;
    end
    // Pulse lasts one cycle, clears itself
    nxt_endp   = sw_fall & ~ctrl_ff.grid_only;
    nxt_endp_d = endp_ff;
    if (ctrl_ff.grid_only)
    begin
      nxt_qual_run = 1'b0;
      nxt_slow     = 1'b0;
      nxt_qual_cnt = '0;
    end
    // Set wins over the end clear so a fresh start is never lost
    nxt_start = (start_ff & ~gend_ff) | start_set | ctrl_ff.grid_only;
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      sw_prev_ff  <= 1'b0;
      qual_run_ff <= 1'b0;
      qual_cnt_ff <= '0;
      slow_ff     <= 1'b0;
      endp_ff     <= 1'b0;
      endp_d_ff   <= 1'b0;
      start_ff    <= 1'b0;
    end
    else
    begin
      sw_prev_ff  <= nxt_sw_prev;
      qual_run_ff <= nxt_qual_run;
      qual_cnt_ff <= nxt_qual_cnt;
      slow_ff     <= nxt_slow;
      endp_ff     <= nxt_endp;
      endp_d_ff   <= nxt_endp_d;
      start_ff    <= nxt_start;
    end
  end

  // Divider chain: 25 MHz to 625 kHz to vertical clock
  assign vgate     = start_ff | ctrl_ff.free_run;
  assign tick_fast = (fast_cnt_ff == 6'(grseq_pkg::FAST_DIV - 1));
  assign tick_slow = tick_fast & (slow_cnt_ff == 3'(grseq_pkg::SLOW_DIV - 1));
  assign vclk      = vgate & tick_fast
                   & (line_cnt_ff == 6'(grseq_pkg::LINE_PULSES - 1));
  assign major_now = vclk & (div5_ff == 3'h0);

  // Dot source select per line type and mode
  always_comb
  begin
    trig = 1'b0;
    if (vgate && dot_en_ff)
    begin
      if (ctrl_ff.display)
        trig = major_ff ? tick_fast : tick_slow;
      else
        trig = major_ff & tick_slow;
    end
  end

  always_comb
  begin
    nxt_fast_cnt = tick_fast ? 6'h00 : fast_cnt_ff + 6'h01;
    nxt_line_cnt = line_cnt_ff;
    nxt_slow_cnt = slow_cnt_ff;
    nxt_div5     = div5_ff;
    nxt_major    = major_ff;
    nxt_mos_cnt  = dec(mos_cnt_ff);
    nxt_dot_en   = dot_en_ff;
    nxt_dot_cnt  = dec(dot_cnt_ff);
    nxt_col_cnt  = col_cnt_ff;
    nxt_gend     = 1'b0;
    nxt_st       = st_ff;
    if (tick_fast)
    begin
      nxt_line_cnt = (line_cnt_ff == 6'(grseq_pkg::LINE_PULSES - 1)) ? 6'h00
                     : line_cnt_ff + 6'h01;
      nxt_slow_cnt = (slow_cnt_ff == 3'(grseq_pkg::SLOW_DIV - 1)) ? 3'h0
                     : slow_cnt_ff + 3'h1;
    end
    if (vclk)
    begin
      // One line per vertical scan; slow phase restarts so it gives nine
      nxt_slow_cnt = 3'h0;
      nxt_div5   = (div5_ff == 3'(grseq_pkg::MAJOR_EVERY - 1)) ? 3'h0
                   : div5_ff + 3'h1;
      nxt_major  = major_now;
      nxt_dot_en = ~major_now;
      if (major_now)
        nxt_mos_cnt = delay_ff;
    end
    if (major_ff && mos_cnt_ff == CW'(1))
      nxt_dot_en = 1'b1;
    if (trig)
      nxt_dot_cnt = dotw_ff;
    case (st_ff)
      grseq_pkg::GS_IDLE:
      begin
        if (start_ff)
          nxt_st = grseq_pkg::GS_WAIT_MAJOR;
      end
      grseq_pkg::GS_WAIT_MAJOR:
      begin
        if (major_now)
          nxt_st = grseq_pkg::GS_STEP;
      end
      grseq_pkg::GS_STEP:
      begin
        if (major_now)
        begin
          nxt_col_cnt = col_cnt_ff + 4'h1;
          if (col_cnt_ff == 4'(grseq_pkg::COLUMN_LAST - 1))
          begin
            nxt_col_cnt = 4'h0;
            nxt_gend    = 1'b1;
            nxt_st      = grseq_pkg::GS_IDLE;
          end
        end
      end
      default:
        nxt_st = grseq_pkg::GS_IDLE;
    endcase
    if (!vgate)
    begin
      // Stopped dividers restart cleanly so the first line is major
      nxt_line_cnt = 6'h00;
      nxt_slow_cnt = 3'h0;
      nxt_div5     = 3'h0;
      nxt_major    = 1'b0;
      nxt_dot_en   = 1'b0;
    end
    if (!start_ff)
    begin
      nxt_st      = grseq_pkg::GS_IDLE;
      nxt_col_cnt = 4'h0;
    end
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      fast_cnt_ff <= 6'h00;
      line_cnt_ff <= 6'h00;
      slow_cnt_ff <= 3'h0;
      div5_ff     <= 3'h0;
      major_ff    <= 1'b0;
      mos_cnt_ff  <= '0;
      dot_en_ff   <= 1'b0;
      dot_cnt_ff  <= '0;
      col_cnt_ff  <= 4'h0;
      gend_ff     <= 1'b0;
      st_ff       <= grseq_pkg::GS_IDLE;
    end
    else
    begin
      fast_cnt_ff <= nxt_fast_cnt;
      line_cnt_ff <= nxt_line_cnt;
      slow_cnt_ff <= nxt_slow_cnt;
      div5_ff     <= nxt_div5;
      major_ff    <= nxt_major;
      mos_cnt_ff  <= nxt_mos_cnt;
      dot_en_ff   <= nxt_dot_en;
      dot_cnt_ff  <= nxt_dot_cnt;
      col_cnt_ff  <= nxt_col_cnt;
      gend_ff     <= nxt_gend;
      st_ff       <= nxt_st;
    end
  end

  // Registered outputs
  always_comb
  begin
    nxt_out.lockout   = ctrl_ff.grid_only | (start_ff & slow_ff);
    nxt_out.inhibit   = ctrl_ff.grid_only | start_ff;
    nxt_out.src_sel   = ctrl_ff.grid_only | start_ff;
    // Held in reset from grid end until first major line
    nxt_out.ramp_rst  = (st_ff != grseq_pkg::GS_STEP);
    nxt_out.trim_gate = sw_act & ~start_ff;
    nxt_out.dot       = (dot_cnt_ff != '0);
    nxt_out.vclk      = vclk;
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      out_ff <= grseq_pkg::OUT_RST;
    else
      out_ff <= nxt_out;
  end

  assign hrdata                   = hrdata_ff;
  assign hreadyout                = hready_ff;
  assign hresp                    = hresp_ff;
  assign sweep_lockout            = out_ff.lockout;
  assign beam_inhibit             = out_ff.inhibit;
  assign deflection_source_select = out_ff.src_sel;
  assign column_ramp_reset        = out_ff.ramp_rst;
  assign trimmed_sweep_gate       = out_ff.trim_gate;
  assign dot_pulse                = out_ff.dot;
  assign vertical_clock           = out_ff.vclk;
endmodule

//--- common/grseq_pkg.sv
// Constants and types for the grid overlay sequencer.
// Assumes a single 25 MHz clock and an AHB-Lite register slave.
package grseq_pkg;
  localparam int CLK_KHZ       = 25000;
  localparam int CLK_PERIOD_NS = 40;
  localparam int FAST_KHZ      = 625;
  localparam int SLOW_KHZ      = 125;
  localparam int FAST_DIV      = CLK_KHZ / FAST_KHZ;
  localparam int SLOW_DIV      = FAST_KHZ / SLOW_KHZ;
  localparam int LINE_PULSES   = 45;
  localparam int DOT_SKIP      = 4;
  localparam int MAJOR_EVERY   = 5;
  localparam int COLUMN_LAST   = 10;
  localparam int QUAL_TIME_NS  = 50000;
  localparam int QUAL_CYCLES   = (QUAL_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int DOT_TIME_NS   = 160;
  localparam int DOT_CYCLES    = (DOT_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int CW            = 16;
  localparam logic [7:0] ADDR_CTRL   = 8'h00;
  localparam logic [7:0] ADDR_QUAL   = 8'h04;
  localparam logic [7:0] ADDR_DELAY  = 8'h08;
  localparam logic [7:0] ADDR_DOTW   = 8'h0c;
  localparam logic [7:0] ADDR_STATUS = 8'h10;
  localparam logic [CW-1:0] QUAL_RST  = CW'(QUAL_CYCLES);
  localparam logic [CW-1:0] DELAY_RST = CW'(DOT_SKIP * FAST_DIV);
  localparam logic [CW-1:0] DOTW_RST  = CW'(DOT_CYCLES);
  typedef struct packed {
    logic free_run;
    logic display;
    logic grid_only;
  } grseq_ctrl_type;
  localparam grseq_ctrl_type CTRL_RST = 3'h2;
  typedef struct packed {
    logic lockout;
    logic inhibit;
    logic src_sel;
    logic ramp_rst;
    logic trim_gate;
    logic dot;
    logic vclk;
  } grseq_out_type;
  localparam grseq_out_type OUT_RST = 7'h08;
  typedef enum logic [1:0] {GS_IDLE, GS_WAIT_MAJOR, GS_STEP} grseq_state_type;
endpackage

//--- bench/grseq_sweep_model.sv
// Behavioural time-base sweep driving the active-low sweep gate.
// Assumes fire is a one-cycle request from the bench.
`timescale 1ns/1ps
module grseq_sweep_model (
  input  wire logic        hclk,
  input  wire logic        fire,
  input  wire logic [15:0] sweep_len,
  output logic             sweep_gate_n
);
  logic [15:0] left_ff = 16'h0;
  logic [15:0] nxt_left;
  // Short length gives a fast sweep, long a slow one
  always_comb
  begin
    nxt_left = (left_ff != 16'h0) ? left_ff - 16'h1 : 16'h0;
    if (fire)
      nxt_left = sweep_len;
  end
  always_ff @(posedge hclk)
  begin
    left_ff <= nxt_left;
  end
  // Actively driven, so it idles high between sweeps
  assign sweep_gate_n = (left_ff == 16'h0);
endmodule

//--- bench/grseq_chk_sva.sv
// Checker for the grid sequencer control outputs.
// Assumes the dot width register keeps its reset value.
`timescale 1ns/1ps
module grseq_chk (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic sweep_lockout,
  input wire logic beam_inhibit,
  input wire logic deflection_source_select,
  input wire logic column_ramp_reset,
  input wire logic trimmed_sweep_gate,
  input wire logic dot_pulse,
  input wire logic vertical_clock
);
  logic [10:0] gap_ff;
  logic [10:0] nxt_gap;
  logic        seen_ff;
  logic        nxt_seen;
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);
  // Gap only judged once a scan has been seen in this run
  always_comb
  begin
    nxt_gap  = vertical_clock ? 11'h0 : gap_ff + 11'h1;
    nxt_seen = beam_inhibit & (seen_ff | vertical_clock);
  end
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      gap_ff  <= 11'h0;
      seen_ff <= 1'b0;
    end
    else
    begin
      gap_ff  <= nxt_gap;
      seen_ff <= nxt_seen;
    end
  end
  a_src_follow: assert property (deflection_source_select == beam_inhibit)
    else $error("source select differs from inhibit");
  a_lock_grid: assert property (sweep_lockout |-> beam_inhibit)
    else $error("lockout outside grid");
  a_trim_excl: assert property (beam_inhibit [*2] |-> !trimmed_sweep_gate)
    else $error("trimmed gate during grid");
  a_ramp_rel: assert property ($fell(column_ramp_reset) |->
    $past(vertical_clock) && beam_inhibit)
    else $error("ramp released off a scan");
  a_ramp_hold: assert property (column_ramp_reset && !beam_inhibit |=> column_ramp_reset)
    else $error("ramp reset dropped while idle");
  a_end_restore: assert property ($fell(beam_inhibit) |->
    !sweep_lockout && !deflection_source_select && column_ramp_reset)
    else $error("grid end left outputs set");
  a_vclk_gap: assert property (vertical_clock && seen_ff |->
    gap_ff == 11'(grseq_pkg::LINE_PULSES * grseq_pkg::FAST_DIV - 1))
    else $error("scan period wrong");
  a_dot_width: assert property ($rose(dot_pulse) |-> dot_pulse [*4] ##1 !dot_pulse)
    else $error("dot width wrong");
endmodule
bind grseq_top grseq_chk u_chk (.hclk(hclk), .hresetn(hresetn),
  .sweep_lockout(sweep_lockout), .beam_inhibit(beam_inhibit),
  .deflection_source_select(deflection_source_select),
  .column_ramp_reset(column_ramp_reset), .trimmed_sweep_gate(trimmed_sweep_gate),
  .dot_pulse(dot_pulse), .vertical_clock(vertical_clock));

//--- bench/tb_top.sv
// Self-checking bench for the grid sequencer.
// Assumes a zero-wait slave; full grid cycle takes about 92k clocks.
`timescale 1ns/1ps
module tb_top;
  typedef struct packed {
    logic        w;
    logic [7:0]  a;
    logic [31:0] d;
    logic [31:0] e;
  } grseq_row_type;
  localparam grseq_row_type ROWS [9] = '{
    '{1'b0, grseq_pkg::ADDR_CTRL, 32'h0, 32'(grseq_pkg::CTRL_RST)},
    '{1'b0, grseq_pkg::ADDR_QUAL, 32'h0, 32'(grseq_pkg::QUAL_RST)},
    '{1'b0, grseq_pkg::ADDR_DELAY, 32'h0, 32'(grseq_pkg::DELAY_RST)},
    '{1'b0, grseq_pkg::ADDR_DOTW, 32'h0, 32'(grseq_pkg::DOTW_RST)},
    '{1'b0, grseq_pkg::ADDR_STATUS, 32'h0, 32'h8},
    '{1'b0, 8'h14, 32'h0, 32'h0},
    '{1'b1, 8'h14, 32'h5, 32'h0},
    '{1'b1, grseq_pkg::ADDR_STATUS, 32'hff, 32'h8},
    '{1'b1, grseq_pkg::ADDR_QUAL, 32'h14, 32'h14}};
  logic        hclk = 1'b0;
  logic        hresetn = 1'b0;
  logic        hsel = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0]  htrans = 2'h0;
  logic        hwrite = 1'b0;
  logic [31:0] hwdata = 32'h0;
  logic [31:0] hrdata;
  logic        hreadyout, hresp, sweep_gate_n, sweep_lockout, beam_inhibit;
  logic        deflection_source_select, column_ramp_reset, trimmed_sweep_gate;
  logic        dot_pulse, vertical_clock;
  logic        fire = 1'b0;
  logic [15:0] sweep_len = 16'h0;
  logic [31:0] rd;
  int          error_cnt = 0;
  int          checks = 0;
  int          cnt;
  int          n;
  always #20 hclk = ~hclk;
  grseq_top dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .sweep_gate_n(sweep_gate_n),
    .sweep_lockout(sweep_lockout), .beam_inhibit(beam_inhibit),
    .deflection_source_select(deflection_source_select),
    .column_ramp_reset(column_ramp_reset), .trimmed_sweep_gate(trimmed_sweep_gate),
    .dot_pulse(dot_pulse), .vertical_clock(vertical_clock));
  grseq_sweep_model sweep (.hclk(hclk), .fire(fire), .sweep_len(sweep_len),
    .sweep_gate_n(sweep_gate_n));
  task automatic wrap_up();
    $display("Checks %0d, errors %0d", checks, error_cnt);
    if (error_cnt == 0 && checks > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  task automatic fail_to();
    $display("Error at %0t: wait timed out", $time);
    error_cnt++;
    wrap_up();
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp)
    begin
      $display("Error at %0t: got %h, want %h", $time, got, exp);
      error_cnt++;
    end
  endtask
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] r);
    int k;
    k = 0;
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= {24'h0, a};
    hwrite <= w;
    do begin @(posedge hclk); k++; end while (hreadyout !== 1'b1 && k < 20);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    do begin @(posedge hclk); k++; end while (hreadyout !== 1'b1 && k < 40);
    r = hrdata;
    if (k >= 40) fail_to();
  endtask
  // Selector keeps one bounded wait for the three watched outputs
  task automatic wait_for(input int w, input logic lvl, input int lim);
    int k;
    logic s;
    for (k = 0; k <= lim; k++)
    begin
      s = (w == 0) ? beam_inhibit : (w == 1) ? vertical_clock : column_ramp_reset;
      if (s === lvl) break;
      @(posedge hclk);
    end
    if (k > lim) fail_to();
  endtask
  // Counts dot rises up to the next scan pulse, plus the dot fired with it
  task automatic count_dots(output int c);
    int   k;
    logic prev;
    c = 0;
    k = 0;
    prev = dot_pulse;
    do
    begin
      @(posedge hclk);
      if (dot_pulse === 1'b1 && prev !== 1'b1) c++;
      prev = dot_pulse;
      k++;
    end while (vertical_clock !== 1'b1 && k < 2500);
    if (k >= 2500) fail_to();
    // Last dot of a line rises one cycle after the scan pulse shows
    @(posedge hclk);
    if (dot_pulse === 1'b1 && prev !== 1'b1) c++;
  endtask
  task automatic go(input logic [15:0] len);
    sweep_len <= len;
    fire <= 1'b1;
    @(posedge hclk);
    fire <= 1'b0;
  endtask
  task automatic do_reset();
    hresetn <= 1'b0;
    repeat (10) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
  endtask
  initial
  begin
    do_reset();
    chk(column_ramp_reset, 1'b1);
    chk(beam_inhibit, 1'b0);
    foreach (ROWS[i])
    begin
      if (ROWS[i].w) bus(1'b1, ROWS[i].a, ROWS[i].d, rd);
      bus(1'b0, ROWS[i].a, 32'h0, rd);
      chk(rd, ROWS[i].e);
      chk(hresp, 1'b0);
    end
    // Fast sweep, then a second sweep that must not reach the trimmed gate
    go(16'ha);
    repeat (8) @(posedge hclk);
    chk(trimmed_sweep_gate, 1'b1);
    chk(beam_inhibit, 1'b0);
    wait_for(0, 1'b1, 30);
    chk(sweep_lockout, 1'b0);
    chk(deflection_source_select, 1'b1);
    chk(column_ramp_reset, 1'b1);
    go(16'h40);
    repeat (10) @(posedge hclk);
    chk(trimmed_sweep_gate, 1'b0);
    wait_for(2, 1'b0, 2500);
    do_reset();
    bus(1'b1, grseq_pkg::ADDR_QUAL, 32'h14, rd);
    // Slow sweep and one whole grid cycle in display mode
    go(16'h64);
    wait_for(0, 1'b1, 200);
    chk(sweep_lockout, 1'b1);
    wait_for(1, 1'b1, 2500);
    count_dots(cnt);
    chk(cnt, 32'd41);
    count_dots(cnt);
    chk(cnt, 32'd9);
    cnt = 3;
    for (n = 0; n < 95000 && beam_inhibit === 1'b1; n++)
    begin
      @(posedge hclk);
      if (vertical_clock === 1'b1) cnt++;
    end
    if (n >= 95000) fail_to();
    chk(cnt, 1 + grseq_pkg::COLUMN_LAST * grseq_pkg::MAJOR_EVERY);
    chk(sweep_lockout, 1'b0);
    chk(deflection_source_select, 1'b0);
    chk(column_ramp_reset, 1'b1);
    repeat (50) @(posedge hclk);
    chk(beam_inhibit, 1'b0);
    chk(column_ramp_reset, 1'b1);
    // Grid-only in digitize mode starts with no sweep at all
    bus(1'b1, grseq_pkg::ADDR_CTRL, 32'h1, rd);
    wait_for(0, 1'b1, 10);
    chk(sweep_lockout, 1'b1);
    chk(deflection_source_select, 1'b1);
    wait_for(1, 1'b1, 2500);
    count_dots(cnt);
    chk(cnt, 32'd9);
    count_dots(cnt);
    chk(cnt, 32'd0);
    do_reset();
    // Test setting runs the scan dividers without a start
    bus(1'b1, grseq_pkg::ADDR_CTRL, 32'h6, rd);
    wait_for(1, 1'b1, 2500);
    chk(beam_inhibit, 1'b0);
    wrap_up();
  end
endmodule
